// [srda_top.sv]
// Receive deserializer with frame alignment, loss-of-signal muting and APB status
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module srda_top
#(
  parameter int REC_BIT_CYC_HIGH = srda_pkg::REC_BIT_CYC,
  parameter int REC_BIT_CYC_LOW  = srda_pkg::REC_BIT_CYC
)
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line and external recovered clock
  input  wire logic        rx_serial_in_pos,
  input  wire logic        rx_serial_in_neg,
  input  wire logic        ext_rec_clk_pos,
  input  wire logic        ext_rec_clk_neg,
  // Control pins
  input  wire logic        recovery_bypass,
  input  wire logic        rate_select,
  input  wire logic        out_of_frame_in,
  input  wire logic        loss_detect_off,
  input  wire logic        module_signal_detect_n,
  // Parallel output to the framer
  output logic [7:0]       rx_par_data,
  output logic             rx_par_clk,
  output logic             frame_sync_pulse,
  // Interrupt
  output logic             irq
);

  localparam int NSYNC = 9;
  localparam int PW    = 8;

  // Pin synchronisers
  logic [NSYNC-1:0] pins_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;

  assign pins_in = {rx_serial_in_pos, rx_serial_in_neg, ext_rec_clk_pos, ext_rec_clk_neg,
                    recovery_bypass, rate_select, out_of_frame_in, loss_detect_off,
                    module_signal_detect_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= pins_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic line_bit;
  logic ext_clk;
  logic bypass_s;
  logic rate_s;
  logic search_s;
  logic los_off_s;
  logic sd_n_s;

  assign line_bit  = sync2_reg[8] & ~sync2_reg[7];
  assign ext_clk   = sync2_reg[6] & ~sync2_reg[5];
  assign bypass_s  = sync2_reg[4];
  assign rate_s    = sync2_reg[3];
  assign search_s  = sync2_reg[2];
  assign los_off_s = sync2_reg[1];
  assign sd_n_s    = sync2_reg[0];

  // Bit recovery: external clock edge in bypass, else a phase counter re-centred on data edges
  logic          ext_clk_prev_reg;
  logic          line_prev_reg;
  logic [PW-1:0] phase_reg;
  logic [PW-1:0] bit_cyc;
  logic          bit_tick;

  assign bit_cyc = rate_s ? PW'(REC_BIT_CYC_HIGH) : PW'(REC_BIT_CYC_LOW);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_clk_prev_reg <= 1'b0;
      line_prev_reg    <= 1'b0;
    end
    else
    begin
      ext_clk_prev_reg <= ext_clk;
      line_prev_reg    <= line_bit;
    end
  end

  // The phase counter only stands in for the analog loop; it tracks edges, not jitter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_reg <= '0;
    else if (line_bit != line_prev_reg || phase_reg >= bit_cyc - 1'b1)
      phase_reg <= '0;
    else
      phase_reg <= phase_reg + 1'b1;
  end

  always_comb
  begin
    if (bypass_s)
      bit_tick = ext_clk & ~ext_clk_prev_reg;
    else
      bit_tick = (phase_reg == (bit_cyc >> 1)) && (line_bit == line_prev_reg);
  end

  // Line delay; the loss monitor taps the undelayed bit so muting is not held back
  logic [srda_pkg::LINE_DLY_BITS-1:0] dly_reg;
  logic                               dly_bit;

  assign dly_bit = dly_reg[srda_pkg::LINE_DLY_BITS-1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dly_reg <= '0;
    else if (bit_tick)
      dly_reg <= {dly_reg[srda_pkg::LINE_DLY_BITS-2:0], line_bit};
  end

  // Deserializer and frame hunt
  logic [31:0] hunt_reg;
  logic [31:0] hunt_next;
  logic [2:0]  bit_cnt_reg;
  logic        match;
  logic        byte_done;

  assign hunt_next = {hunt_reg[30:0], dly_bit};
  assign match     = search_s && (hunt_next == srda_pkg::FRAME_PATTERN);
  assign byte_done = match || (bit_cnt_reg == srda_pkg::LAST_BIT_IDX);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hunt_reg <= '0;
    else if (bit_tick)
      hunt_reg <= hunt_next;
  end

  // Boundary moves only on a match, which needs out-of-frame high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bit_cnt_reg <= 3'h0;
    else if (bit_tick && byte_done)
      bit_cnt_reg <= 3'h0;
    else if (bit_tick)
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end

  // Parallel clock: falls with each new word, rises mid-byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_par_clk <= 1'b0;
    else if (bit_tick && byte_done)
      rx_par_clk <= 1'b0;
    else if (bit_tick && bit_cnt_reg == srda_pkg::CLK_RISE_IDX)
      rx_par_clk <= 1'b1;
  end

  // Frame pulse spans exactly one word period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_sync_pulse <= 1'b0;
    else if (bit_tick && byte_done)
      frame_sync_pulse <= match;
  end

  // Loss of signal
  logic los;
  logic los_prev_reg;
  logic ctrl_mute_reg;
  logic mute;

  srda_los_monitor u_los
  (
    .clk      (pclk),
    .rst_n    (presetn),
    .bit_tick (bit_tick),
    .bit_val  (line_bit),
    .enable   (!los_off_s),
    .los      (los)
  );

  assign mute = !sd_n_s || (!los_off_s && los) || ctrl_mute_reg;

  // Mute acts at once; fresh data only at word boundaries
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_par_data <= 8'h00;
    else if (mute)
      rx_par_data <= 8'h00;
    else if (bit_tick && byte_done)
      rx_par_data <= hunt_next[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      los_prev_reg <= 1'b0;
    else
      los_prev_reg <= los;
  end

  // Interrupt events
  logic [srda_pkg::IRQ_W-1:0] events;
  logic [srda_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [srda_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [srda_pkg::IRQ_W-1:0] w1c;
  logic                       wr_en;
  logic                       rd_setup;

  always_comb
  begin
    events = '0;
    events[srda_pkg::EV_FRAME_BIT]   = bit_tick && byte_done && match;
    events[srda_pkg::EV_LOS_SET_BIT] = los && !los_prev_reg;
    events[srda_pkg::EV_LOS_CLR_BIT] = !los && los_prev_reg;
  end

  assign wr_en    = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  assign w1c      = (wr_en && paddr == srda_pkg::IRQ_STAT_OFFSET) ?
                    pwdata[srda_pkg::IRQ_W-1:0] : '0;

  // A new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_reg  <= srda_pkg::IRQ_MASK_RST;
      ctrl_mute_reg <= srda_pkg::CTRL_MUTE_RST;
    end
    else if (wr_en && paddr == srda_pkg::IRQ_MASK_OFFSET)
      irq_mask_reg <= pwdata[srda_pkg::IRQ_W-1:0];
    else if (wr_en && paddr == srda_pkg::CTRL_OFFSET)
      ctrl_mute_reg <= pwdata[srda_pkg::CTRL_MUTE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // APB: one wait-free access phase; answer registered in the setup cycle
  logic [31:0] status_word;
  logic [31:0] rdata_next;
  logic        addr_bad;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[srda_pkg::ST_LOS_BIT]    = los;
    status_word[srda_pkg::ST_SEARCH_BIT] = search_s;
    status_word[srda_pkg::ST_SDLOST_BIT] = !sd_n_s;
    status_word[srda_pkg::ST_BYPASS_BIT] = bypass_s;
    status_word[srda_pkg::ST_RATE_BIT]   = rate_s;
    status_word[srda_pkg::ST_MUTED_BIT]  = mute;
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    addr_bad   = 1'b0;
    if (paddr == srda_pkg::STATUS_OFFSET)
      rdata_next = status_word;
    else if (paddr == srda_pkg::IRQ_STAT_OFFSET)
      rdata_next = {{(32-srda_pkg::IRQ_W){1'b0}}, irq_stat_reg};
    else if (paddr == srda_pkg::IRQ_MASK_OFFSET)
      rdata_next = {{(32-srda_pkg::IRQ_W){1'b0}}, irq_mask_reg};
    else if (paddr == srda_pkg::CTRL_OFFSET)
      rdata_next = {31'h0, ctrl_mute_reg};
    else
      addr_bad = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= rd_setup;
      pslverr <= rd_setup && addr_bad;
      if (rd_setup && !pwrite)
        prdata <= rdata_next;
      else if (!psel)
        prdata <= 32'h0000_0000;
    end
  end

endmodule

// [srda_pkg.sv]
// Shared constants for the SONET receive deserializer and aligner
package srda_pkg;

  // Clock and line timing
  localparam int          PCLK_PERIOD_NS   = 40;
  localparam int          BIT_PERIOD_NS    = 320;
  localparam int          REC_BIT_CYC      = (BIT_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  // Bits held back before assembly, so a byte leaves about 32 bit periods after its first bit
  localparam int          LINE_DLY_BITS    = 24;

  // Word format
  localparam int          WORD_W           = 8;
  localparam logic [2:0]  LAST_BIT_IDX     = 3'h7;
  localparam logic [2:0]  CLK_RISE_IDX     = 3'h3;

  // Framing: one A1 followed by three A2 marks the third A2
  localparam logic [7:0]  A1_BYTE          = 8'hF6;
  localparam logic [7:0]  A2_BYTE          = 8'h28;
  localparam logic [31:0] FRAME_PATTERN    = {A1_BYTE, A2_BYTE, A2_BYTE, A2_BYTE};

  // Loss of signal
  localparam int          LOS_ZERO_RUN     = 128;
  localparam int          LOS_WINDOW       = 128;
  localparam int          LOS_CLEAR_TRANS  = 16;

  // APB register byte offsets
  localparam logic [7:0]  STATUS_OFFSET    = 8'h00;
  localparam logic [7:0]  IRQ_STAT_OFFSET  = 8'h04;
  localparam logic [7:0]  IRQ_MASK_OFFSET  = 8'h08;
  localparam logic [7:0]  CTRL_OFFSET      = 8'h0C;

  // Status fields
  localparam int          ST_LOS_BIT       = 0;
  localparam int          ST_SEARCH_BIT    = 1;
  localparam int          ST_SDLOST_BIT    = 2;
  localparam int          ST_BYPASS_BIT    = 3;
  localparam int          ST_RATE_BIT      = 4;
  localparam int          ST_MUTED_BIT     = 5;

  // Interrupt event fields
  localparam int          IRQ_W            = 3;
  localparam int          EV_FRAME_BIT     = 0;
  localparam int          EV_LOS_SET_BIT   = 1;
  localparam int          EV_LOS_CLR_BIT   = 2;

  // Control fields and reset values
  localparam int          CTRL_MUTE_BIT    = 0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic        CTRL_MUTE_RST    = 1'b0;

endpackage

// [srda_los_monitor.sv]
// Loss-of-signal monitor: zero-run detection and sliding-window transition count
`timescale 1ns/100ps
module srda_los_monitor
#(
  parameter int ZERO_RUN    = srda_pkg::LOS_ZERO_RUN,
  parameter int WINDOW      = srda_pkg::LOS_WINDOW,
  parameter int CLEAR_TRANS = srda_pkg::LOS_CLEAR_TRANS
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Recovered bit stream
  input  wire logic bit_tick,
  input  wire logic bit_val,
  input  wire logic enable,
  // Result
  output logic      los
);

  localparam int CW = $clog2(WINDOW + 1);
  localparam int ZW = $clog2(ZERO_RUN + 1);

  logic [WINDOW-1:0] win_reg;
  logic [CW-1:0]     tcnt_reg;
  logic [CW-1:0]     tcnt_next;
  logic [ZW-1:0]     zrun_reg;
  logic              prev_reg;
  logic              los_reg;
  logic              trans;

  assign trans     = bit_val ^ prev_reg;
  assign tcnt_next = tcnt_reg + CW'(trans) - CW'(win_reg[WINDOW-1]);
  assign los       = los_reg;

  // Window of transition marks, one per bit period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_reg  <= '0;
      tcnt_reg <= '0;
      prev_reg <= 1'b0;
    end
    else if (!enable)
    begin
      win_reg  <= '0;
      tcnt_reg <= '0;
      prev_reg <= bit_val;
    end
    else if (bit_tick)
    begin
      win_reg  <= {win_reg[WINDOW-2:0], trans};
      tcnt_reg <= tcnt_next;
      prev_reg <= bit_val;
    end
  end

  // Zero run saturates so a long outage cannot wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      zrun_reg <= '0;
    else if (!enable || (bit_tick && bit_val))
      zrun_reg <= '0;
    else if (bit_tick && zrun_reg != ZW'(ZERO_RUN))
      zrun_reg <= zrun_reg + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      los_reg <= 1'b0;
    else if (!enable)
      los_reg <= 1'b0;
    else if (bit_tick && !bit_val && zrun_reg == ZW'(ZERO_RUN - 1))
      los_reg <= 1'b1;
    else if (bit_tick && los_reg && tcnt_next >= CW'(CLEAR_TRANS))
      los_reg <= 1'b0;
  end

endmodule

// [srda_top_props.sv]
// Port checker for the receive deserializer
`timescale 1ns/100ps
module srda_top_props
#(
  parameter int REC_BIT_CYC_HIGH = 8
)
(
  // Bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Framer side
  input wire logic        out_of_frame_in,
  input wire logic        module_signal_detect_n,
  input wire logic [7:0]  rx_par_data,
  input wire logic        rx_par_clk,
  input wire logic        frame_sync_pulse
);
  localparam int WORD_CYC = 8 * REC_BIT_CYC_HIGH;
  int   pcnt;
  int   fcnt;
  logic ck_q;
  logic fp_q;
  logic seen;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A realign restarts the word period, so it restarts the count too
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pcnt <= 0;
      fcnt <= 0;
      ck_q <= 1'b0;
      fp_q <= 1'b0;
      seen <= 1'b0;
    end
    else
    begin
      pcnt <= frame_sync_pulse ? pcnt + 1 : 0;
      ck_q <= rx_par_clk;
      fp_q <= frame_sync_pulse;
      seen <= seen | (ck_q & ~rx_par_clk);
      fcnt <= ((ck_q && !rx_par_clk) || (!fp_q && frame_sync_pulse)) ? 1 : fcnt + 1;
    end
  end
  a_data_on_fall: assert property ($rose(rx_par_clk) |-> $stable(rx_par_data) ||
    rx_par_data == 8'h00 || $past(rx_par_data) == 8'h00) else $error("data moved off clock fall");
  a_pulse_a2: assert property ($rose(frame_sync_pulse) |-> !rx_par_clk && rx_par_data == 8'h28)
    else $error("pulse not on A2 word");
  a_pulse_width: assert property ($fell(frame_sync_pulse) |-> pcnt == WORD_CYC && $fell(rx_par_clk))
    else $error("pulse not one word long");
  a_pulse_search: assert property ($rose(frame_sync_pulse) |-> $past(out_of_frame_in, 2) ||
    $past(out_of_frame_in, 3) || $past(out_of_frame_in, 4)) else $error("pulse without search");
  a_word_period: assert property ($fell(rx_par_clk) && seen && !frame_sync_pulse |-> fcnt == WORD_CYC)
    else $error("word period wrong");
  a_clk_low: assert property ($fell(rx_par_clk) |=> !rx_par_clk [*8])
    else $error("parallel clock low too short");
  a_sd_zero: assert property (!module_signal_detect_n [*5] |-> rx_par_data == 8'h00)
    else $error("data not forced low");
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
    else $error("pslverr wrong");
  c_pulse: cover property ($rose(frame_sync_pulse));
  c_err: cover property (pready && pslverr);
  c_sd: cover property (!module_signal_detect_n [*8]);
endmodule

// [srda_line_model.sv]
// Line source: serial bits MSB first with a free-running recovered clock
`timescale 1ns/100ps
module srda_line_model
(
  // Line pins
  output logic ser_pos,
  output logic ser_neg,
  output logic clk_pos,
  output logic clk_neg
);
  logic q[$];
  logic cur;
  initial
  begin
    cur = 1'b0;
    clk_pos = 1'b0;
    #7;
    forever
    begin
      #160 clk_pos = 1'b1;
      #160 clk_pos = 1'b0;
      // Data moves half a bit from the sampling edge; idle toggles to avoid a false loss
      cur = (q.size() > 0) ? q.pop_front() : ~cur;
    end
  end
  assign ser_pos = cur;
  assign ser_neg = ~cur;
  assign clk_neg = ~clk_pos;
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      q.push_back(b[i]);
  endtask
  task automatic run(input int n, input logic v);
    repeat (n) q.push_back(v);
  endtask
endmodule

// [sonet_rx_deserializer_align_tb.sv]
// Bench: APB access, framing, loss of signal and muting
`timescale 1ns/100ps
module sonet_rx_deserializer_align_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, par_data;
  logic [31:0] pwdata, prdata;
  logic        sp, sn, cp, cn, byp, rate, srch, lof, sd_n, par_clk, fsp, irq, ck_q, fp_q;
  int          mismatches, comparisons, pulses, pidx;
  logic [7:0]  words[$];
  logic [7:0]  fr[6] = '{8'hF6, 8'h28, 8'h28, 8'h28, 8'hA5, 8'h3C};
  srda_top dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_serial_in_pos(sp),
    .rx_serial_in_neg(sn), .ext_rec_clk_pos(cp), .ext_rec_clk_neg(cn), .recovery_bypass(byp),
    .rate_select(rate), .out_of_frame_in(srch), .loss_detect_off(lof), .module_signal_detect_n(sd_n),
    .rx_par_data(par_data), .rx_par_clk(par_clk), .frame_sync_pulse(fsp), .irq(irq)
  );
  srda_line_model line_u (.ser_pos(sp), .ser_neg(sn), .clk_pos(cp), .clk_neg(cn));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // A realign may load a word while the parallel clock is already low
  always @(posedge pclk)
  begin
    ck_q <= par_clk;
    fp_q <= fsp;
    if ((ck_q && !par_clk) || (fsp && !fp_q))
      words.push_back(par_data);
    if (fsp && !fp_q)
    begin
      pulses++;
      pidx = words.size() - 1;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string s);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp, s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic drain(input int left, input int extra);
    while (line_u.q.size() > left)
      @(posedge pclk);
    repeat (extra) @(posedge pclk);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    logic [31:0] r;
    logic        e;
    {mismatches, comparisons, pulses} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {byp, rate, srch, lof, sd_n} = 5'b11001;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    check(par_data, 8'h00, "reset data");
    rd(srda_pkg::STATUS_OFFSET, 32'h18, "status");
    rd(srda_pkg::IRQ_MASK_OFFSET, 32'h0, "mask");
    rd(srda_pkg::CTRL_OFFSET, 32'h0, "ctrl");
    apb(1'b0, 8'h10, 32'h0, r, e);
    check({r[30:0], e}, 32'h1, "unmapped");
    rate <= 1'b0;
    wr(srda_pkg::STATUS_OFFSET, 32'hFF);
    rd(srda_pkg::STATUS_OFFSET, 32'h08, "status ro");
    srch <= 1'b1;
    line_u.run(3, 1'b1);
    foreach (fr[i]) line_u.put(fr[i]);
    // Last A2 bit just left the line; its first bit went 56 cycles earlier, so 144 and 224 mark 25 and 35 bits
    drain(16, 0);
    repeat (144) @(posedge pclk);
    check(pulses, 0, "early pulse");
    repeat (80) @(posedge pclk);
    check(pulses, 1, "pulses");
    drain(0, 150);
    check(words[pidx], 8'h28, "a2 word");
    check(words[pidx + 1], 8'hA5, "word 1");
    check(words[pidx + 2], 8'h3C, "word 2");
    check(irq, 1'b0, "masked irq");
    rd(srda_pkg::IRQ_STAT_OFFSET, 32'h1, "frame event");
    wr(srda_pkg::IRQ_MASK_OFFSET, 32'h7);
    @(posedge pclk);
    check(irq, 1'b1, "irq");
    wr(srda_pkg::IRQ_STAT_OFFSET, 32'h1);
    @(posedge pclk);
    check(irq, 1'b0, "irq clear");
    srch <= 1'b0;
    line_u.run(5, 1'b1);
    foreach (fr[i]) line_u.put(fr[i]);
    drain(0, 300);
    check(pulses, 1, "no search");
    line_u.run(1, 1'b1);
    line_u.run(127, 1'b0);
    drain(0, 40);
    rd(srda_pkg::IRQ_STAT_OFFSET, 32'h0, "short run");
    line_u.run(1, 1'b1);
    line_u.run(200, 1'b0);
    for (int i = 0; i < 15; i++)
      line_u.run(1, ~i[0]);
    line_u.run(40, 1'b1);
    drain(10, 0);
    rd(srda_pkg::STATUS_OFFSET, 32'h29, "los held");
    check(par_data, 8'h00, "muted");
    drain(0, 300);
    rd(srda_pkg::STATUS_OFFSET, 32'h08, "los clear");
    rd(srda_pkg::IRQ_STAT_OFFSET, 32'h6, "los events");
    wr(srda_pkg::IRQ_STAT_OFFSET, 32'h6);
    lof <= 1'b1;
    line_u.run(1, 1'b1);
    line_u.run(150, 1'b0);
    line_u.run(60, 1'b1);
    drain(5, 0);
    rd(srda_pkg::STATUS_OFFSET, 32'h08, "no monitor");
    check(par_data, 8'hFF, "not muted");
    lof <= 1'b0;
    sd_n <= 1'b0;
    repeat (6) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      check(par_data, 8'h00, "sd mute");
      repeat (9) @(posedge pclk);
    end
    rd(srda_pkg::STATUS_OFFSET, 32'h2C, "sd lost");
    sd_n <= 1'b1;
    repeat (400) @(posedge pclk);
    check({7'h0, par_data == 8'h55 || par_data == 8'hAA}, 8'h01, "sd back");
    wr(srda_pkg::CTRL_OFFSET, 32'h1);
    rd(srda_pkg::CTRL_OFFSET, 32'h1, "ctrl rw");
    check(par_data, 8'h00, "sw mute");
    wr(srda_pkg::CTRL_OFFSET, 32'h0);
    print_verdict();
  end
  initial
  begin
    #2000000;
    mismatches++;
    print_verdict();
  end
endmodule
bind srda_top srda_top_props #(.REC_BIT_CYC_HIGH(REC_BIT_CYC_HIGH)) props_u
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .out_of_frame_in(out_of_frame_in),
  .module_signal_detect_n(module_signal_detect_n), .rx_par_data(rx_par_data), .rx_par_clk(rx_par_clk),
  .frame_sync_pulse(frame_sync_pulse)
);
